// [rtl/hbgfi_consts.svh]
// Timing figures and derived cycle counts for the half-bridge interlock core.
// Assumes a 200 MHz core clock.
`ifndef HBGFI_CONSTS_SVH
`define HBGFI_CONSTS_SVH

`define HBGFI_CLK_MHZ 200
`define HBGFI_CLEAR_HOLD_NS 9000
`define HBGFI_CLEAR_HOLD_CYC ((`HBGFI_CLEAR_HOLD_NS * `HBGFI_CLK_MHZ + 999) / 1000 + 1)
`define HBGFI_FILT_MIN_NS 625
`define HBGFI_FILT_CYC ((`HBGFI_FILT_MIN_NS * `HBGFI_CLK_MHZ + 999) / 1000)
`define HBGFI_POR_MS 150
`define HBGFI_POR_CYC (`HBGFI_POR_MS * 1000 * `HBGFI_CLK_MHZ)
`define HBGFI_DEAD_CYC 200
`define HBGFI_BLANK_CYC 600

`endif

// [rtl/hbgfi_core.sv]
// Half-bridge gate interlock and fault latch core.
// Assumes command, shutdown and sense inputs arrive asynchronously from pins.
// Contract
// - Any fault sets latch and flag
// - Latched fault ignores all commands
// - Off gates stay off while latched
// - Clear needs no fault, commands low 9us
// - Flag is open drain, low means ok
// - Low shutdown input latches fault
// - Shutdown clears after release and 9us low
// - Shutdown inactive when high or open
// - Gates never on together
// - Dead time overlaps controller gap
// - Dead time fixed, no setting
// - Delay is dead time plus pipeline
// - Both commands high turns both off
// - Single channel toggling gets no dead time
// - Overlap raises no fault
// - Desat checked only while gate on
// - Desat blanked after each turn on
// - Desat trip turns off, latches fault
// - Blanking resets when gate turns off
// - Undervoltage forces off and latches fault
// - Short command pulses are filtered out
// - Power-on reset gates operation 150ms
// - Commands active high
`timescale 1ns/1ps
`include "hbgfi_consts.svh"
module hbgfi_core #(
  parameter int POR_CYC = `HBGFI_POR_CYC,
  parameter int CLEAR_HOLD_CYC = `HBGFI_CLEAR_HOLD_CYC,
  parameter int BLANK_CYC = `HBGFI_BLANK_CYC,
  parameter int FILT_CYC = `HBGFI_FILT_CYC
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Controller commands and shutdown
  input wire logic i_high_side_cmd,
  input wire logic i_low_side_cmd,
  input wire logic i_external_shutdown_in_n,
  // Analog comparator flags
  input wire logic i_high_side_sense_in,
  input wire logic i_low_side_sense_in,
  input wire logic i_supply_undervolt,
  // Gate outputs
  output logic o_high_gate,
  output logic o_low_gate,
  // Fault flag, open drain
  input wire logic i_fault_flag_out,
  output logic o_fault_flag_out,
  output logic o_fault_flag_out_oe
);
  localparam int DEAD_CYC = `HBGFI_DEAD_CYC;

  // Two-stage synchronisers for all pin inputs
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] raw_in;
  assign raw_in = {i_high_side_cmd, i_low_side_cmd, i_external_shutdown_in_n,
                   i_high_side_sense_in, i_low_side_sense_in, i_supply_undervolt};
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= 6'h08;
      sync2 <= 6'h08;
    end else if (i_ce) begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  logic hs_sense;
  logic ls_sense;
  logic undervolt;
  logic shutdown;
  assign hs_sense = sync2[2];
  assign ls_sense = sync2[1];
  assign undervolt = sync2[0];
  assign shutdown = !sync2[3];

  // Glitch filters on both commands
  logic hs_cmd;
  logic ls_cmd;
  hbgfi_glitch_filter #(.FILT_CYC(FILT_CYC)) u_filt_hs (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_raw(sync2[5]), .o_filt(hs_cmd));
  hbgfi_glitch_filter #(.FILT_CYC(FILT_CYC)) u_filt_ls (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_raw(sync2[4]), .o_filt(ls_cmd));

  // Desaturation monitors
  logic hs_trip;
  logic ls_trip;
  hbgfi_desat_protection #(.BLANK_CYC(BLANK_CYC)) u_desat_hs (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_gate_on(o_high_gate), .i_sense(hs_sense), .o_trip(hs_trip));
  hbgfi_desat_protection #(.BLANK_CYC(BLANK_CYC)) u_desat_ls (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_gate_on(o_low_gate), .i_sense(ls_sense), .o_trip(ls_trip));

  logic fault_src;
  assign fault_src = hs_trip || ls_trip || undervolt || shutdown;

  // Fault state machine and counters
  hbgfi_pkg::hbgfi_state_t state;
  hbgfi_pkg::hbgfi_state_t next_state;
  logic [27:0] por_cnt;
  logic [27:0] next_por_cnt;
  logic [11:0] hold_cnt;
  logic [11:0] next_hold_cnt;
  logic latched;

  assign latched = (state != hbgfi_pkg::HBGFI_RUN);

  always_comb begin
    next_state = state;
    next_por_cnt = por_cnt;
    next_hold_cnt = 12'h000;
    unique case (state)
      hbgfi_pkg::HBGFI_POR: begin
        if (por_cnt < 28'(POR_CYC - 1)) begin
          next_por_cnt = por_cnt + 28'h0000001;
        end else if (!fault_src) begin
          next_state = hbgfi_pkg::HBGFI_RUN;
        end else begin
          next_state = hbgfi_pkg::HBGFI_FAULT;
        end
      end
      hbgfi_pkg::HBGFI_RUN: begin
        if (fault_src) begin
          next_state = hbgfi_pkg::HBGFI_FAULT;
        end
      end
      hbgfi_pkg::HBGFI_FAULT: begin
        // Fault present or any command high restarts the hold count
        if (!fault_src && !hs_cmd && !ls_cmd) begin
          if (hold_cnt >= 12'(CLEAR_HOLD_CYC - 1)) begin
            next_state = hbgfi_pkg::HBGFI_RUN;
          end else begin
            next_hold_cnt = hold_cnt + 12'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= hbgfi_pkg::HBGFI_POR;
      por_cnt <= 28'h0000000;
      hold_cnt <= 12'h000;
    end else if (i_ce) begin
      state <= next_state;
      por_cnt <= next_por_cnt;
      hold_cnt <= next_hold_cnt;
    end
  end

  // Interlock: a channel turns on only after the other has been off DEAD_CYC
  logic [7:0] hs_off_cnt;
  logic [7:0] ls_off_cnt;
  logic [7:0] next_hs_off_cnt;
  logic [7:0] next_ls_off_cnt;
  logic next_high_gate;
  logic next_low_gate;
  logic block;
  logic overlap;

  assign overlap = hs_cmd && ls_cmd;
  assign block = latched || fault_src;

  always_comb begin
    // Off counters count how long the opposite command has been low
    next_hs_off_cnt = hs_cmd ? 8'h00 : ((hs_off_cnt < 8'(DEAD_CYC)) ? hs_off_cnt + 8'h01 : hs_off_cnt);
    next_ls_off_cnt = ls_cmd ? 8'h00 : ((ls_off_cnt < 8'(DEAD_CYC)) ? ls_off_cnt + 8'h01 : ls_off_cnt);
    next_high_gate = 1'b0;
    next_low_gate = 1'b0;
    if (!block && !overlap) begin
      // Controller gap counts toward the dead time, so no extra delay
      next_high_gate = hs_cmd && (ls_off_cnt >= 8'(DEAD_CYC)) && !o_low_gate;
      next_low_gate = ls_cmd && (hs_off_cnt >= 8'(DEAD_CYC)) && !o_high_gate;
    end
  end

  // Fault flag released to the pull-up when latched; driven low means no fault
  logic next_flag_oe;
  assign next_flag_oe = !(latched || fault_src);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hs_off_cnt <= 8'h00;
      ls_off_cnt <= 8'h00;
      o_high_gate <= 1'b0;
      o_low_gate <= 1'b0;
      o_fault_flag_out_oe <= 1'b0;
      o_fault_flag_out <= 1'b0;
    end else if (i_ce) begin
      hs_off_cnt <= next_hs_off_cnt;
      ls_off_cnt <= next_ls_off_cnt;
      o_high_gate <= next_high_gate;
      o_low_gate <= next_low_gate;
      o_fault_flag_out_oe <= next_flag_oe;
      o_fault_flag_out <= 1'b0;
    end
  end

  // Checks
  chk_never_both_on: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(o_high_gate && o_low_gate))
    else $error("both gates on");
  chk_latched_gates_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && $past(latched) && latched) |-> !o_high_gate && !o_low_gate)
    else $error("gate on while latched");
  chk_fault_flag_oe: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_FAULT) |=> !o_fault_flag_out_oe)
    else $error("flag not released while latched");
  chk_overlap_no_fault: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == hbgfi_pkg::HBGFI_RUN && overlap && !fault_src && i_ce) |=> state == hbgfi_pkg::HBGFI_RUN)
    else $error("overlap latched a fault");
  chk_overlap_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (overlap && i_ce) |=> !o_high_gate && !o_low_gate)
    else $error("gate on during overlap");
  chk_shutdown_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (shutdown && state == hbgfi_pkg::HBGFI_RUN && i_ce) |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("shutdown did not latch");
  chk_clear_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ($past(state) == hbgfi_pkg::HBGFI_FAULT && state == hbgfi_pkg::HBGFI_RUN)
      |-> $past(hold_cnt) == 12'(CLEAR_HOLD_CYC - 1))
    else $error("latch cleared early");
  chk_undervolt_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (undervolt && i_ce) |=> !o_high_gate && !o_low_gate)
    else $error("gate on under undervoltage");
  chk_desat_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (hs_trip && i_ce) |=> !o_high_gate)
    else $error("desat did not turn gate off");
  chk_por_latched: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == hbgfi_pkg::HBGFI_POR) |-> !o_high_gate && !o_low_gate)
    else $error("gate on during power-on");


  // Fault flag follows the latch
  chk_flag_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && fault_src) |=> !o_fault_flag_out_oe)
    else $error("fault did not raise flag");
  chk_flag_ok: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_RUN && !fault_src) |=> o_fault_flag_out_oe)
    else $error("flag shows fault while healthy");

  // Undervoltage and desat latch from run; low desat turns its gate off
  chk_undervolt_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && undervolt && state == hbgfi_pkg::HBGFI_RUN) |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("undervoltage did not latch");
  chk_desat_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && (hs_trip || ls_trip) && state == hbgfi_pkg::HBGFI_RUN) |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("desat did not latch");
  chk_low_desat_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ls_trip && i_ce) |=> !o_low_gate)
    else $error("low desat did not turn gate off");

  // Latch holds while a fault or a command remains
  chk_hold_on_fault: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_FAULT && fault_src) |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("latch cleared with fault active");
  chk_hold_on_cmd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_FAULT && (hs_cmd || ls_cmd)) |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("latch cleared with command high");

  // Gates only follow a high command
  chk_high_needs_cmd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !hs_cmd) |=> !o_high_gate)
    else $error("high gate on without command");
  chk_low_needs_cmd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !ls_cmd) |=> !o_low_gate)
    else $error("low gate on without command");

  // Dead time measured from the other command going low
  chk_high_gap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && ls_off_cnt < 8'(DEAD_CYC)) |=> !o_high_gate)
    else $error("high gate inside dead time");
  chk_low_gap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && hs_off_cnt < 8'(DEAD_CYC)) |=> !o_low_gate)
    else $error("low gate inside dead time");
  chk_single_pass: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !block && hs_cmd && !ls_cmd && ls_off_cnt >= 8'(DEAD_CYC) && !o_low_gate)
      |=> o_high_gate)
    else $error("single channel edge held back");

  // Power-on interval and clock enable
  chk_por_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_POR && por_cnt < 28'(POR_CYC - 1))
      |=> state == hbgfi_pkg::HBGFI_POR)
    else $error("power-on interval cut short");
  chk_por_fault_exit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && state == hbgfi_pkg::HBGFI_POR && por_cnt >= 28'(POR_CYC - 1) && fault_src)
      |=> state == hbgfi_pkg::HBGFI_FAULT)
    else $error("power-on ended clear with fault");
  chk_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_ce |=> $stable(state) && $stable(o_high_gate) && $stable(o_low_gate))
    else $error("state moved with enable low");

  // Main scenarios
  cov_overlap: cover property (@(posedge i_clk) disable iff (!i_arst_n) hs_cmd && ls_cmd);
  cov_high_on: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_high_gate));
  cov_low_on: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_low_gate));
  cov_fault_enter: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    state == hbgfi_pkg::HBGFI_RUN ##1 state == hbgfi_pkg::HBGFI_FAULT);
  cov_fault_clear: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    state == hbgfi_pkg::HBGFI_FAULT ##1 state == hbgfi_pkg::HBGFI_RUN);
endmodule

// [rtl/hbgfi_desat_protection.sv]
// Desaturation protection per channel: blanking after turn-on, then trip.
// Assumes synchronised sense input and the channel's registered gate state.
`timescale 1ns/1ps
`include "hbgfi_consts.svh"
module hbgfi_desat_protection #(
  parameter int BLANK_CYC = `HBGFI_BLANK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Gate state and sense
  input wire logic i_gate_on,
  input wire logic i_sense,
  output logic o_trip
);
  logic [11:0] blank_cnt;
  logic [11:0] next_blank_cnt;

  // Blanking counter restarts whenever gate is off
  always_comb begin
    next_blank_cnt = blank_cnt;
    if (!i_gate_on) begin
      next_blank_cnt = 12'h000;
    end else if (blank_cnt < 12'(BLANK_CYC)) begin
      next_blank_cnt = blank_cnt + 12'h001;
    end
  end

  // Trip only while on and blanking done
  assign o_trip = i_gate_on && (blank_cnt >= 12'(BLANK_CYC)) && i_sense;

  // Register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blank_cnt <= 12'h000;
    end else if (i_ce) begin
      blank_cnt <= next_blank_cnt;
    end
  end

  // A gate that was off restarts blanking, so no trip can follow at once
  chk_blank_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_gate_on) |=> (blank_cnt == 12'h000) && !o_trip)
    else $error("desat trip inside blanking");
endmodule

// [rtl/hbgfi_glitch_filter.sv]
// Glitch filter: a level change must persist for the filter count to pass.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`include "hbgfi_consts.svh"
module hbgfi_glitch_filter #(
  parameter int FILT_CYC = `HBGFI_FILT_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Data
  input wire logic i_raw,
  output logic o_filt
);
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic next_filt;

  // Count while input differs from output, flip at count
  always_comb begin
    next_cnt = 12'h000;
    next_filt = o_filt;
    if (i_raw != o_filt) begin
      if (cnt >= 12'(FILT_CYC - 1)) begin
        next_filt = i_raw;
      end else begin
        next_cnt = cnt + 12'h001;
      end
    end
  end

  // Register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 12'h000;
      o_filt <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      o_filt <= next_filt;
    end
  end
endmodule

// [rtl/hbgfi_pkg.sv]
// Types shared by the half-bridge interlock core.
// Assumes nothing beyond the constants header.
package hbgfi_pkg;
  typedef enum logic [1:0] {
    HBGFI_POR,
    HBGFI_RUN,
    HBGFI_FAULT
  } hbgfi_state_t;
endpackage

// [verif/hbgfi_pwm_model.sv]
// PWM controller model: registers requested commands for the core.
// Assumes the core's clock and reset; POR_CYC matches the core's setting.
`timescale 1ns/1ps
module hbgfi_pwm_model #(
  parameter int POR_CYC = 50
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Requests from the bench
  input wire logic i_hs_req,
  input wire logic i_ls_req,
  // Commands to the core
  output logic o_high_side_cmd,
  output logic o_low_side_cmd
);
  int cnt;
  int next_cnt;
  logic next_hs;
  logic next_ls;
  // Commands stay low until power-on reset is over
  always_comb begin
    next_cnt = (cnt < POR_CYC) ? cnt + 1 : cnt;
    next_hs = (cnt >= POR_CYC) && i_hs_req;
    next_ls = (cnt >= POR_CYC) && i_ls_req;
  end
  // Register count and commands
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_high_side_cmd <= 1'b0;
      o_low_side_cmd <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_high_side_cmd <= next_hs;
      o_low_side_cmd <= next_ls;
    end
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the half-bridge interlock core.
// Assumes shortened counts: POR 50, clear hold 20, blanking 10, filter 4.
`timescale 1ns/1ps
module tb_top;
  localparam int FC = 4;
  logic i_clk = 1'b0, i_arst_n = 1'b0;
  logic hs = 1'b0, ls = 1'b0, sd_n = 1'b1, sh = 1'b0, sl = 1'b0, uv = 1'b0, ce = 1'b1;
  logic hc, lc, hg, lg, ff, ffoe, pin;
  int miscompares = 0, n_tests = 0, n;
  // Pull-up on the open-drain flag
  assign pin = ffoe ? ff : 1'b1;
  hbgfi_pwm_model #(.POR_CYC(50)) ctl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hs_req(hs),
    .i_ls_req(ls), .o_high_side_cmd(hc), .o_low_side_cmd(lc));
  hbgfi_core #(.POR_CYC(50), .CLEAR_HOLD_CYC(20), .BLANK_CYC(10), .FILT_CYC(FC)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_high_side_cmd(hc), .i_low_side_cmd(lc),
    .i_external_shutdown_in_n(sd_n), .i_high_side_sense_in(sh), .i_low_side_sense_in(sl),
    .i_supply_undervolt(uv), .o_high_gate(hg), .o_low_gate(lg), .i_fault_flag_out(pin),
    .o_fault_flag_out(ff), .o_fault_flag_out_oe(ffoe));
  // Clock
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // Cycles until a watched line reaches a level, max if never
  task automatic wait_for(input int sel, input logic lvl, input int max, output int k);
    for (k = 0; k < max; k++) begin
      if ((sel == 0 ? hg : sel == 1 ? lg : pin) === lvl) break;
      cyc(1);
    end
  endtask
  // Shoot-through watch on every falling edge
  always @(negedge i_clk) begin
    if (hg === 1'b1 && lg === 1'b1) chk(1'b1, 1'b0);
  end
  task automatic t_por;
    cyc(20);
    chk(pin, 1'b1);
    chk(hg, 1'b0);
    wait_for(2, 1'b0, 100, n);
    chk(n < 100, 1'b1);
  endtask
  task automatic t_single(input int s);
    cyc(220);
    @(posedge i_clk) if (s == 0) hs <= 1'b1; else ls <= 1'b1;
    cyc(1);
    wait_for(s, 1'b1, 40, n);
    chk(n >= FC + 2 && n <= FC + 4, 1'b1);
    @(posedge i_clk) if (s == 0) hs <= 1'b0; else ls <= 1'b0;
    cyc(1);
    wait_for(s, 1'b0, 40, n);
    chk(n >= FC + 2 && n <= FC + 4, 1'b1);
  endtask
  // Enable low freezes the core; it resumes afterwards
  task automatic t_ce;
    cyc(220);
    @(posedge i_clk) begin ce <= 1'b0; hs <= 1'b1; end
    cyc(20);
    chk(hg, 1'b0);
    @(posedge i_clk) ce <= 1'b1;
    cyc(1);
    wait_for(0, 1'b1, 40, n);
    chk(n >= FC + 2 && n <= FC + 4, 1'b1);
    @(posedge i_clk) hs <= 1'b0;
    cyc(1);
    wait_for(0, 1'b0, 40, n);
    chk(n >= FC + 2 && n <= FC + 4, 1'b1);
  endtask
  task automatic t_dead;
    cyc(220);
    @(posedge i_clk) hs <= 1'b1;
    cyc(20);
    @(posedge i_clk) begin hs <= 1'b0; ls <= 1'b1; end
    cyc(1);
    wait_for(1, 1'b1, 400, n);
    chk(n >= 200 && n <= 200 + FC + 6, 1'b1);
    @(posedge i_clk) ls <= 1'b0;
  endtask
  task automatic t_overlap;
    cyc(220);
    @(posedge i_clk) begin hs <= 1'b1; ls <= 1'b1; end
    cyc(30);
    chk(hg | lg, 1'b0);
    chk(pin, 1'b0);
    @(posedge i_clk) begin hs <= 1'b0; ls <= 1'b0; end
    cyc(220);
    // Pulse one cycle shorter than the filter
    @(posedge i_clk) hs <= 1'b1;
    repeat (FC - 1) @(posedge i_clk);
    hs <= 1'b0;
    wait_for(0, 1'b1, 20, n);
    chk(n == 20, 1'b1);
  endtask
  task automatic t_shutdown;
    cyc(220);
    @(posedge i_clk) hs <= 1'b1;
    cyc(20);
    @(posedge i_clk) sd_n <= 1'b0;
    cyc(1);
    wait_for(2, 1'b1, 6, n);
    chk(n < 6, 1'b1);
    chk(hg, 1'b0);
    @(posedge i_clk) begin hs <= 1'b0; ls <= 1'b1; end
    cyc(20);
    chk(lg, 1'b0);
    @(posedge i_clk) begin ls <= 1'b0; sd_n <= 1'b1; end
    cyc(10);
    chk(pin, 1'b1);
    wait_for(2, 1'b0, 60, n);
    chk(n < 60, 1'b1);
  endtask
  task automatic t_desat;
    cyc(220);
    @(posedge i_clk) sl <= 1'b1;
    cyc(20);
    chk(pin, 1'b0);
    @(posedge i_clk) begin sl <= 1'b0; hs <= 1'b1; end
    cyc(1);
    wait_for(0, 1'b1, 40, n);
    @(posedge i_clk) sh <= 1'b1;
    cyc(4);
    chk(hg, 1'b1);
    chk(pin, 1'b0);
    wait_for(2, 1'b1, 20, n);
    chk(n < 20, 1'b1);
    chk(hg, 1'b0);
    @(posedge i_clk) begin sh <= 1'b0; hs <= 1'b0; end
    wait_for(2, 1'b0, 60, n);
    chk(n < 60, 1'b1);
  endtask
  task automatic t_uv;
    cyc(220);
    @(posedge i_clk) hs <= 1'b1;
    cyc(20);
    @(posedge i_clk) uv <= 1'b1;
    cyc(1);
    wait_for(2, 1'b1, 6, n);
    chk(n < 6, 1'b1);
    chk(hg, 1'b0);
    @(posedge i_clk) uv <= 1'b0;
    cyc(60);
    chk(pin, 1'b1);
    @(posedge i_clk) hs <= 1'b0;
    wait_for(2, 1'b0, 60, n);
    chk(n < 60, 1'b1);
  endtask
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    @(posedge i_clk) i_arst_n <= 1'b1;
    t_por();
    t_single(0);
    t_single(1);
    t_ce();
    t_dead();
    t_overlap();
    t_shutdown();
    t_desat();
    t_uv();
    print_verdict();
  end
endmodule
